// ---- pkg/seq_pkg.sv ----
/*
   Shared constants, types and helpers for the five-position homing sequencer.
   Assumes one system clock domain and motor positions counted in signed steps.
*/
package seq_pkg;

   // -----------------------------------------------------------------
   // Widths and counts
   // -----------------------------------------------------------------
   localparam int POS_W         = 32;
   localparam int SPEED_W       = 16;
   localparam int SEL_W         = 3;
   localparam int NUM_TARGETS   = 5;
   localparam int IN_W          = 7;
   localparam int OUT_W         = 3;
   localparam int SYNC_W        = 15;
   // One motor shaft revolution in position steps
   localparam int STEPS_PER_REV = 4096;

   // -----------------------------------------------------------------
   // Digital input and output bit positions
   // -----------------------------------------------------------------
   localparam int IN_POS_START  = 1;
   localparam int IN_HOME_CMD   = 2;
   localparam int IN_HOME_SENSE = 3;
   localparam int IN_SEL_LO     = 4;
   localparam int OUT_HOMING    = 0;
   localparam int OUT_POSITION  = 1;
   localparam int OUT_MANUAL    = 2;

   // Synchroniser lane positions beyond the digital inputs
   localparam int SY_HEALTHY    = 7;
   localparam int SY_MANUAL     = 8;
   localparam int SY_PLUS       = 9;
   localparam int SY_MINUS      = 10;
   localparam int SY_CONFIRM    = 11;
   localparam int SY_SLOT_LO    = 12;

   // -----------------------------------------------------------------
   // Reset values and the valid selection code range
   // -----------------------------------------------------------------
   localparam logic [POS_W-1:0]   ZERO_POS   = 32'h0;
   localparam logic [SPEED_W-1:0] ZERO_SPEED = 16'h0;
   localparam logic [SEL_W-1:0]   SEL_FIRST  = 3'h1;
   localparam logic [SEL_W-1:0]   SEL_LAST   = 3'h5;

   typedef logic signed [POS_W-1:0] pos_t;
   typedef enum logic [1:0] {ST_WAIT_HOME, ST_HOMING, ST_READY, ST_JOG} seq_state_t;

   // True when a selection code names one of the stored targets
   function automatic logic slotValid(input logic [SEL_W-1:0] code);
      return (code >= SEL_FIRST) && (code <= SEL_LAST);
   endfunction

   function automatic logic [POS_W-1:0] magnitude(input pos_t v);
      return v[POS_W-1] ? POS_W'(-v) : POS_W'(v);
   endfunction

endpackage

// ---- pkg/target_if.sv ----
/*
   Carrier between the sequencer and its target table.
   Assumes both ends run on the same clock.
*/
`timescale 1ns/10ps
interface target_if;
   import seq_pkg::*;

   logic [SEL_W-1:0] selCode;
   logic [POS_W-1:0] selTarget;
   logic             teachEn;
   logic [SEL_W-1:0] teachSlot;
   logic [POS_W-1:0] teachPos;
   logic             loadEn;
   logic [SEL_W-1:0] loadSlot;
   logic [POS_W-1:0] loadData;

   modport store (input selCode, teachEn, teachSlot, teachPos, loadEn, loadSlot, loadData, output selTarget);
   modport seq   (output selCode, teachEn, teachSlot, teachPos, loadEn, loadSlot, loadData, input selTarget);
endinterface

// ---- hw/input_sync.sv ----
/*
   Two-flop synchroniser with rising-edge detection for a group of pins.
   Assumes each pin is a slow level or a pulse longer than two clock periods.
*/
`timescale 1ns/10ps
module input_sync #(
   parameter int W = 8
) (
   input  wire logic         clk,
   input  wire logic         nrst,
   input  wire logic [W-1:0] pinIn,
   output logic      [W-1:0] level,
   output logic      [W-1:0] rise
);
   logic [W-1:0] meta_q;
   logic [W-1:0] sync_q;
   logic [W-1:0] prev_q;

   // Only the second stage and later feed the edge detector
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         meta_q <= '0;
         sync_q <= '0;
         prev_q <= '0;
      end
      else
      begin
         meta_q <= pinIn;
         sync_q <= meta_q;
         prev_q <= sync_q;
      end
   end

   assign level = sync_q;
   assign rise  = sync_q & ~prev_q;
endmodule

// ---- hw/target_store.sv ----
/*
   Table of five stored target positions with selection decode and teach-in.
   Assumes the sequencer drives at most one write source per cycle; teach wins.
*/
`timescale 1ns/10ps
module target_store
   import seq_pkg::*;
(
   input  wire logic clk,
   input  wire logic nrst,
   target_if.store   tgt
);
   logic [POS_W-1:0] targets [1:NUM_TARGETS];
   logic             teachHit;
   logic             loadHit;

   assign teachHit = tgt.teachEn && slotValid(tgt.teachSlot);
   assign loadHit  = tgt.loadEn && slotValid(tgt.loadSlot);

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         for (int i = 1; i <= NUM_TARGETS; i++)
            targets[i] <= ZERO_POS;
      end
      else if (teachHit)
         targets[tgt.teachSlot] <= tgt.teachPos;
      else if (loadHit)
         targets[tgt.loadSlot] <= tgt.loadData;
   end

   // Codes outside one to five fall back to the homed zero
   assign tgt.selTarget = slotValid(tgt.selCode) ? targets[tgt.selCode] : ZERO_POS;
endmodule

// ---- hw/five_position_homing_sequencer.sv ----
/*
   Homing and five-position sequencer for one servo axis.
   Assumes a motion core on the same clock that runs trapezoidal profiles in steps,
   reports profileActive and motorPosition, and runs at velocitySpeed while velocityRun.
*/
// Overview of operation
// - A homing pulse on input 2 turns the motor at homing speed until the sensor on input 3 is active.
// - Homing starts only while homing is not done; later homing pulses are ignored.
// - The sensor during unfinished homing resets position counters, sets homing done and drops output 0.
// - Positioning mode is enabled only once homing is done.
// - At power-up the enable flag is set once if the drive is healthy, but the mode output stays off until homing is done; a one-shot flag blocks repeats.
// - Inputs 6,5,4 form a code; 1 to 5 pick a stored target, anything else picks zero.
// - The selected target is latched only while no profile runs.
// - A pulse on input 1 starts a trapezoidal move to the selected target.
// - Distance is target minus motor position; a negative result sets the direction bit and uses its magnitude.
// - Targets are steps from the homed zero, 4096 steps to a shaft turn.
// - Three status outputs show homing, positioning and manual translation.
// - In manual mode plus and minus toggle a jog in their direction at manual speed.
// - Confirm in manual mode stores the motor position in the slot chosen for teaching.
`timescale 1ns/10ps
module five_position_homing_sequencer
   import seq_pkg::*;
(
   input  wire logic               clk,
   input  wire logic               nrst,
   input  wire logic [IN_W-1:0]    inputTerminalStrip,
   input  wire logic               driveHealthy,
   input  wire logic               manualMode,
   input  wire logic               keyPlus,
   input  wire logic               keyMinus,
   input  wire logic               keyConfirm,
   input  wire logic [SEL_W-1:0]   teachSlot,
   input  wire logic [SPEED_W-1:0] homingSpeed,
   input  wire logic [SPEED_W-1:0] manualJogSpeed,
   input  wire logic               paramWrEn,
   input  wire logic [SEL_W-1:0]   paramWrSlot,
   input  wire logic [POS_W-1:0]   paramWrData,
   input  wire logic [POS_W-1:0]   motorPosition,
   input  wire logic               profileActive,
   output logic      [OUT_W-1:0]   outputTerminalStrip,
   output logic                    homingDone,
   output logic                    operatingModeEnable,
   output logic                    modeCounterReset,
   output logic                    profileStart,
   output logic      [POS_W-1:0]   profileDistance,
   output logic                    moveDirectionNegative,
   output logic                    velocityRun,
   output logic                    velocityNegative,
   output logic      [SPEED_W-1:0] velocitySpeed,
   output logic      [POS_W-1:0]   selectedTarget
);

   // -----------------------------------------------------------------
   // Pin synchronisation
   // -----------------------------------------------------------------
   logic [SYNC_W-1:0] pinLevel;
   logic [SYNC_W-1:0] pinRise;

   input_sync #(.W(SYNC_W)) u_sync (
      .clk   (clk),
      .nrst  (nrst),
      .pinIn ({teachSlot, keyConfirm, keyMinus, keyPlus, manualMode, driveHealthy, inputTerminalStrip}),
      .level (pinLevel),
      .rise  (pinRise)
   );

   logic             homeCmd;
   logic             homeSensor;
   logic             posCmd;
   logic             healthy;
   logic             manualOn;
   logic             plusKey;
   logic             minusKey;
   logic             confirmKey;
   logic [SEL_W-1:0] selCode;
   logic [SEL_W-1:0] slotSel;

   assign homeCmd    = pinRise[IN_HOME_CMD];
   assign homeSensor = pinLevel[IN_HOME_SENSE];
   assign posCmd     = pinRise[IN_POS_START];
   assign healthy    = pinLevel[SY_HEALTHY];
   assign manualOn   = pinLevel[SY_MANUAL];
   assign plusKey    = pinRise[SY_PLUS];
   assign minusKey   = pinRise[SY_MINUS];
   assign confirmKey = pinRise[SY_CONFIRM];
   assign selCode    = pinLevel[IN_SEL_LO +: SEL_W];
   assign slotSel    = pinLevel[SY_SLOT_LO +: SEL_W];

   // -----------------------------------------------------------------
   // Target table
   // -----------------------------------------------------------------
   target_if tgt ();

   target_store u_store (
      .clk  (clk),
      .nrst (nrst),
      .tgt  (tgt)
   );

   // -----------------------------------------------------------------
   // Decisions
   // -----------------------------------------------------------------
   seq_state_t       state_q;
   seq_state_t       state_d;
   logic             homingDone_q;
   logic             opEn_q;
   logic             powerupOnce_q;
   logic             startIssued_q;
   logic             jogNeg_q;
   logic [POS_W-1:0] targetLatch_q;
   logic [OUT_W-1:0] outStrip_q;
   logic             counterReset_q;
   logic             profileStart_q;
   logic [POS_W-1:0] distance_q;
   logic             dirNeg_q;
   logic [SPEED_W-1:0] speed_q;

   logic busy;
   logic startHoming;
   logic homeHit;
   logic posAccept;
   logic jogKey;
   logic jogStop;
   logic teachNow;
   logic idleState;
   pos_t diff;

   assign busy        = profileActive || startIssued_q;
   assign idleState   = (state_q == ST_WAIT_HOME) || (state_q == ST_READY);
   assign startHoming = homeCmd && !homingDone_q && idleState && !busy;
   assign homeHit     = (state_q == ST_HOMING) && homeSensor && !homingDone_q;
   assign posAccept   = posCmd && operatingModeEnable && !busy && (state_q == ST_READY);
   assign jogKey      = manualOn && (plusKey || minusKey);
   // Same-direction key stops; leaving manual mode also stops the jog
   assign jogStop     = !manualOn || (plusKey && !jogNeg_q) || (minusKey && jogNeg_q);
   assign teachNow    = manualOn && confirmKey && (state_q != ST_HOMING);
   // Both operands are steps from the homed zero, so no scaling is needed
   assign diff        = pos_t'(targetLatch_q) - pos_t'(motorPosition);

   always_comb
   begin
      state_d = state_q;
      unique case (state_q)
         ST_WAIT_HOME:
            if (startHoming)
               state_d = ST_HOMING;
            else if (jogKey && !busy)
               state_d = ST_JOG;
         ST_HOMING:
            if (homeHit)
               state_d = ST_READY;
         ST_READY:
            if (jogKey && !busy && !posCmd)
               state_d = ST_JOG;
         ST_JOG:
            if (jogStop)
               state_d = homingDone_q ? ST_READY : ST_WAIT_HOME;
      endcase
   end

   assign tgt.selCode   = selCode;
   assign tgt.teachEn   = teachNow;
   assign tgt.teachSlot = slotSel;
   assign tgt.teachPos  = motorPosition;
   assign tgt.loadEn    = paramWrEn;
   assign tgt.loadSlot  = paramWrSlot;
   assign tgt.loadData  = paramWrData;

   // -----------------------------------------------------------------
   // State and flags
   // -----------------------------------------------------------------
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         state_q       <= ST_WAIT_HOME;
         homingDone_q  <= 1'b0;
         opEn_q        <= 1'b0;
         powerupOnce_q <= 1'b0;
         jogNeg_q      <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
         if (homeHit)
            homingDone_q <= 1'b1;
         if (startHoming)
            opEn_q <= 1'b0;
         else if (homeHit || (healthy && !powerupOnce_q))
            opEn_q <= 1'b1;
         if (healthy)
            powerupOnce_q <= 1'b1;
         if (jogKey && (state_d == ST_JOG))
            jogNeg_q <= minusKey && !plusKey;
      end
   end

   // -----------------------------------------------------------------
   // Profile start and target latch
   // -----------------------------------------------------------------
   // startIssued_q covers the gap until the core raises profileActive
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         startIssued_q  <= 1'b0;
         targetLatch_q  <= ZERO_POS;
         profileStart_q <= 1'b0;
         distance_q     <= ZERO_POS;
         dirNeg_q       <= 1'b0;
      end
      else
      begin
         profileStart_q <= posAccept;
         if (!busy)
            targetLatch_q <= tgt.selTarget;
         if (posAccept)
         begin
            startIssued_q <= 1'b1;
            distance_q    <= magnitude(diff);
            dirNeg_q      <= diff[POS_W-1];
         end
         else if (profileActive)
            startIssued_q <= 1'b0;
      end
   end

   // -----------------------------------------------------------------
   // Outputs
   // -----------------------------------------------------------------
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         outStrip_q     <= '0;
         counterReset_q <= 1'b0;
         speed_q        <= ZERO_SPEED;
      end
      else
      begin
         counterReset_q          <= homeHit;
         outStrip_q[OUT_HOMING]  <= (state_d == ST_HOMING);
         outStrip_q[OUT_POSITION] <= profileActive;
         outStrip_q[OUT_MANUAL]  <= (state_d == ST_JOG);
         speed_q <= (state_d == ST_HOMING) ? homingSpeed
                  : (state_d == ST_JOG) ? manualJogSpeed : ZERO_SPEED;
      end
   end

   assign outputTerminalStrip   = outStrip_q;
   assign homingDone            = homingDone_q;
   assign operatingModeEnable   = opEn_q && homingDone_q;
   assign modeCounterReset      = counterReset_q;
   assign profileStart          = profileStart_q;
   assign profileDistance       = distance_q;
   assign moveDirectionNegative = dirNeg_q;
   assign velocityRun           = (state_q == ST_HOMING) || (state_q == ST_JOG);
   assign velocityNegative      = (state_q == ST_JOG) && jogNeg_q;
   assign velocitySpeed         = speed_q;
   assign selectedTarget        = targetLatch_q;

   // -----------------------------------------------------------------
   // Assertions
   // -----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   sequence s_homeReq;
      homeCmd && !homingDone_q && (state_q == ST_WAIT_HOME) && !busy;
   endsequence

   // The sensor may already be active, so only the first homing cycle is checked
   sequence s_homing;
      (state_q == ST_HOMING) && velocityRun ##0 outStrip_q[OUT_HOMING] && (velocitySpeed == $past(homingSpeed));
   endsequence

   property p_homeRun;
      s_homeReq |=> s_homing;
   endproperty
   a_homeRun: assert property (p_homeRun) else $error("homing did not start");

   property p_noRehome;
      homingDone_q && homeCmd |=> (state_q != ST_HOMING) && !outStrip_q[OUT_HOMING] && homingDone_q;
   endproperty
   a_noRehome: assert property (p_noRehome) else $error("homing restarted after done");

   property p_homeHit;
      homeHit |=> homingDone_q && modeCounterReset && !outStrip_q[OUT_HOMING] ##1 !modeCounterReset;
   endproperty
   a_homeHit: assert property (p_homeHit) else $error("home capture effects wrong");

   property p_modeAfterHome;
      operatingModeEnable |-> homingDone_q;
   endproperty
   a_modeAfterHome: assert property (p_modeAfterHome) else $error("mode enabled before homing");

   property p_powerOnce;
      $rose(powerupOnce_q) && !$past(startHoming) |-> opEn_q;
   endproperty
   a_powerOnce: assert property (p_powerOnce) else $error("power-up enable missing");

   property p_latchHold;
      busy |=> $stable(targetLatch_q);
   endproperty
   a_latchHold: assert property (p_latchHold) else $error("target changed while busy");

   property p_startPulse;
      posAccept |=> profileStart ##1 !profileStart;
   endproperty
   a_startPulse: assert property (p_startPulse) else $error("start pulse wrong");

   property p_direction;
      posAccept |=> moveDirectionNegative == ($signed($past(targetLatch_q)) < $signed($past(motorPosition)));
   endproperty
   a_direction: assert property (p_direction) else $error("direction bit wrong");

   property p_ignore;
      posCmd && (busy || !homingDone_q) |=> !profileStart;
   endproperty
   a_ignore: assert property (p_ignore) else $error("start accepted while busy");

   property p_jogSpeed;
      (state_q == ST_JOG) && $past(state_q == ST_JOG) |-> velocitySpeed == $past(manualJogSpeed);
   endproperty
   a_jogSpeed: assert property (p_jogSpeed) else $error("jog speed wrong");

endmodule

// ---- sim/motion_core_model.sv ----
/*
   Stand-in for the motion core: runs profiles, jogs and reports the motor position.
   Assumes the sequencer pulses profileStart for one cycle on the shared clock.
*/
`timescale 1ns/10ps
module motion_core_model
   import seq_pkg::*;
(
   input  wire logic             clk,
   input  wire logic             nrst,
   input  wire logic             slow,
   input  wire logic             profileStart,
   input  wire logic [POS_W-1:0] profileDistance,
   input  wire logic             moveDirectionNegative,
   input  wire logic             modeCounterReset,
   input  wire logic             velocityRun,
   input  wire logic             velocityNegative,
   output logic                  profileActive,
   output logic      [POS_W-1:0] motorPosition
);
   // -----------------------------------------------------------------
   // Profile engine
   // -----------------------------------------------------------------
   // Coarse 512-step moves keep runs short; ramp shape is not modelled
   logic [POS_W-1:0] remain;
   logic [POS_W-1:0] stepSz;
   logic             negDir;
   int               delay;
   assign stepSz = (remain > 32'h200) ? 32'h200 : remain;
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         profileActive <= 1'b0;
         motorPosition <= '0;
         remain        <= '0;
         negDir        <= 1'b0;
         delay         <= 0;
      end
      else
      begin
         // A slow core leaves the start unanswered for a while
         if (profileStart)
         begin
            delay  <= slow ? 12 : 1;
            remain <= profileDistance;
            negDir <= moveDirectionNegative;
         end
         else if (delay == 1)
         begin
            profileActive <= 1'b1;
            delay         <= 0;
         end
         else if (delay > 1)
            delay <= delay - 1;
         if (modeCounterReset)
            motorPosition <= '0;
         else if (profileActive)
         begin
            motorPosition <= negDir ? motorPosition - stepSz : motorPosition + stepSz;
            remain        <= remain - stepSz;
            if (remain == stepSz)
               profileActive <= 1'b0;
         end
         else if (velocityRun)
            motorPosition <= velocityNegative ? motorPosition - 32'h1 : motorPosition + 32'h1;
      end
   end
endmodule

// ---- sim/five_position_homing_sequencer_tb.sv ----
/*
   Self-checking bench for the five-position homing sequencer.
   Assumes the package, interface, design files and the motion core model compile first.
*/
`timescale 1ns/10ps
`define CHK(a, e) begin testsRun++; if ((a) !== (e)) begin nErrors++; \
   $display("[ERR] t=%0t got=%h exp=%h", $time, (a), (e)); end end
module five_position_homing_sequencer_tb
   import seq_pkg::*;
;
   logic               clk, nrst, driveHealthy, manualMode, keyPlus, keyMinus, keyConfirm;
   logic               paramWrEn, slow, profileActive, homingDone, operatingModeEnable;
   logic               modeCounterReset, profileStart, moveDirectionNegative, velocityRun;
   logic               velocityNegative, posSeen;
   logic [IN_W-1:0]    pins;
   logic [SEL_W-1:0]   teachSlot, paramWrSlot;
   logic [SPEED_W-1:0] homingSpeed, manualJogSpeed, velocitySpeed;
   logic [POS_W-1:0]   paramWrData, motorPosition, profileDistance, selectedTarget;
   logic [OUT_W-1:0]   outStrip;
   logic [POS_W:0]     expQ[$];
   logic [POS_W:0]     expV;
   logic [POS_W-1:0]   tgt[8];
   logic [31:0]        rng;
   int                 nErrors, testsRun, nHomeRst;

   five_position_homing_sequencer dut (.clk, .nrst, .inputTerminalStrip(pins), .driveHealthy, .manualMode,
      .keyPlus, .keyMinus, .keyConfirm, .teachSlot, .homingSpeed, .manualJogSpeed, .paramWrEn, .paramWrSlot,
      .paramWrData, .motorPosition, .profileActive, .outputTerminalStrip(outStrip), .homingDone,
      .operatingModeEnable, .modeCounterReset, .profileStart, .profileDistance, .moveDirectionNegative,
      .velocityRun, .velocityNegative, .velocitySpeed, .selectedTarget);
   motion_core_model core (.clk, .nrst, .slow, .profileStart, .profileDistance, .moveDirectionNegative,
      .modeCounterReset, .velocityRun, .velocityNegative, .profileActive, .motorPosition);

   // -----------------------------------------------------------------
   // Helpers
   // -----------------------------------------------------------------
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // Pins are synchronised, so every level is held long enough to be seen
   task automatic pulse(input int b);
      pins[b] = 1'b1;
      cyc(4);
      pins[b] = 1'b0;
      cyc(4);
   endtask
   task automatic tap(ref logic k);
      k = 1'b1;
      cyc(4);
      k = 1'b0;
      cyc(4);
   endtask
   task automatic pick(input logic [2:0] code);
      pins[6:4] = code;
      cyc(6);
   endtask
   task automatic load(input logic [2:0] s, input logic [POS_W-1:0] v);
      paramWrSlot = s;
      paramWrData = v;
      paramWrEn   = 1'b1;
      cyc(1);
      paramWrEn = 1'b0;
      cyc(1);
   endtask
   task automatic waitIdle();
      int i;
      i = 0;
      while ((profileActive || i < 20) && i < 400)
      begin
         cyc(1);
         i++;
      end
      `CHK(profileActive, 1'b0)
   endtask
   task automatic moveTo(input logic [2:0] code);
      pos_t d;
      pick(code);
      `CHK(selectedTarget, tgt[code])
      d = pos_t'(tgt[code]) - pos_t'(motorPosition);
      expQ.push_back({d < 0, d < 0 ? POS_W'(-d) : POS_W'(d)});
      posSeen = 1'b0;
      pulse(IN_POS_START);
      waitIdle();
      `CHK(posSeen, 1'b1)
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", testsRun, nErrors);
      if (nErrors == 0 && testsRun > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // -----------------------------------------------------------------
   // Clock, watchdog and result monitor
   // -----------------------------------------------------------------
   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   initial
   begin
      #2000000;
      nErrors++;
      summarize();
   end
   // Every start pulse must match the oldest expected move
   always @(negedge clk)
   begin
      if (profileStart === 1'b1)
      begin
         if (expQ.size() == 0)
            `CHK(profileStart, 1'b0)
         else
         begin
            expV = expQ.pop_front();
            `CHK({moveDirectionNegative, profileDistance}, expV)
         end
      end
      if (outStrip[OUT_POSITION] === 1'b1)
         posSeen = 1'b1;
      if (modeCounterReset === 1'b1)
         nHomeRst++;
   end

   // -----------------------------------------------------------------
   // Main sequence
   // -----------------------------------------------------------------
   initial
   begin
      pins = '0;
      {driveHealthy, manualMode, keyPlus, keyMinus, keyConfirm, paramWrEn, slow, nrst} = 8'h80;
      teachSlot = 3'h3;
      paramWrSlot = 3'h0;
      paramWrData = '0;
      nErrors = 0;
      testsRun = 0;
      nHomeRst = 0;
      posSeen = 1'b0;
      rng = 32'h0000fea8;
      homingSpeed = rng[15:0];
      rng = xs(rng);
      manualJogSpeed = rng[15:0];
      cyc(4);
      nrst = 1'b1;
      `CHK({homingDone, operatingModeEnable, outStrip, profileStart}, 6'h00)
      pulse(IN_POS_START);
      cyc(4);
      `CHK(operatingModeEnable, 1'b0)
      $display("test early start done");
      for (int s = 0; s < 8; s++)
      begin
         rng = xs(rng);
         tgt[s] = (s >= 1 && s <= 5) ? {{18{rng[13]}}, rng[13:0]} : '0;
         load(3'(s), {{18{rng[13]}}, rng[13:0]});
      end
      pulse(IN_HOME_CMD);
      `CHK({velocityRun, velocityNegative, velocitySpeed}, {2'b10, homingSpeed})
      `CHK(outStrip, 3'b001)
      pins[IN_HOME_SENSE] = 1'b1;
      cyc(6);
      `CHK({homingDone, outStrip[OUT_HOMING], velocityRun, motorPosition}, {3'b100, ZERO_POS})
      `CHK(operatingModeEnable, 1'b1)
      pins[IN_HOME_SENSE] = 1'b0;
      pulse(IN_HOME_CMD);
      `CHK({velocityRun, outStrip[OUT_HOMING], homingDone}, 3'b001)
      `CHK(nHomeRst, 1)
      $display("test homing done");
      for (int c = 0; c < 8; c++)
         moveTo(3'(c));
      $display("test all codes done");
      slow = 1'b1;
      tgt[2] = POS_W'(STEPS_PER_REV * 4);
      load(3'h2, tgt[2]);
      pick(3'h2);
      expQ.push_back({1'b0, tgt[2]});
      pins[IN_POS_START] = 1'b1;
      cyc(4);
      pins[IN_POS_START] = 1'b0;
      pick(3'h4);
      `CHK(selectedTarget, tgt[2])
      pulse(IN_POS_START);
      waitIdle();
      `CHK(motorPosition, tgt[2])
      `CHK(expQ.size(), 0)
      $display("test busy start done");
      manualMode = 1'b1;
      cyc(4);
      tap(keyPlus);
      `CHK({velocityRun, velocityNegative, velocitySpeed, outStrip[OUT_MANUAL]}, {2'b10, manualJogSpeed, 1'b1})
      tap(keyMinus);
      `CHK({velocityRun, velocityNegative}, 2'b11)
      tap(keyMinus);
      `CHK({velocityRun, outStrip[OUT_MANUAL]}, 2'b00)
      tgt[3] = motorPosition;
      tap(keyConfirm);
      manualMode = 1'b0;
      pick(3'h3);
      `CHK(selectedTarget, tgt[3])
      $display("test jog and teach done");
      summarize();
   end
endmodule
